// File: hw/mas_status.sv
// Motion axis status ports: three read-only status words behind an APB slave.
// Assumes engine events arrive on pclk and servo pins arrive asynchronously.
// Notes on behaviour
// - Origin-recorded bit shows recorded machine origin.
// - Clear bit mirrors servo clear output level.
// - Settled bit shows active settled input.
// - Alarm bit shows active alarm input.
// - Settle-wait sets after pulses, clears on settled.
// - Timeout end or immediate stop clears settle-wait.
// - Settle-wait means busy; needs settled input enabled.
// - Status ports readable at any time.
// - Three irq lines stay until causes cleared.
// - The three irq lines can drive the shared bus interrupt.
// - Fourth irq shows reserved-queue discard cause.
// - Latched fourth irq clears queue until cleared.
// - Output-zero bit shows general output level.
// - Two routable output levels shown.
// - Cycle irq latched; error, stop outputs not.
// - Input-zero level shown; reserved bits zero.
// - Position compare flags set and clear.
// - Position overflow clears only on preset.
// - Pulse compare flags set and clear.
// - Pulse overflow clears only on preset.
`timescale 1ns/1ps
module mas_status import mas_pkg::*; (
  // APB.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Servo pins and engine events.
  input  wire mas_servo_in_t servo_in,
  input  wire mas_events_t   ev,
  // Outputs to the axis and the bus.
  output logic             servo_clear_output,
  output logic             general_output_zero,
  output logic             settle_wait_flag,
  output logic             axis_busy,
  output logic             reserve_queue_flush,
  output logic             irq_line_three,
  output logic             inta_request
);
  mas_servo_in_t servo_s;
  logic [5:0]    ctl_q;
  logic [2:0]    irq_q;
  logic          irq3_q;
  logic          cyc_q;
  logic          settle_q;
  logic [2:0]    pos_cmp_q;
  logic [2:0]    pls_cmp_q;
  logic          pos_ovf_q;
  logic          pls_ovf_q;
  logic          wr_cmd;
  logic          wr_ctl;
  logic          rd_en;
  logic          mapped;
  logic [31:0]   cmd;
  logic [15:0]   st_servo;
  logic [15:0]   st_irq;
  logic [15:0]   st_cnt;
  logic [31:0]   rd_d;

  // Pins pass two flip-flops before any logic reads them.
  mas_sync #(.WIDTH(3)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .async_in (servo_in),
    .sync_out (servo_s)
  );

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == MAS_SERVO_ORIGIN_STATUS_OFS) || (a == MAS_IRQ_AND_GP_IO_STATUS_OFS) ||
                (a == MAS_COUNTER_COMPARE_STATUS_OFS) || (a == MAS_CONTROL_OFS) ||
                (a == MAS_COMMAND_OFS);
  endfunction

  // Zero wait states; every access completes in its first access cycle.
  assign mapped = is_mapped(paddr);
  assign rd_en  = psel && penable && !pwrite && clk_en;
  assign wr_ctl = psel && penable && pwrite && clk_en && pstrb[0] &&
                  (paddr == MAS_CONTROL_OFS);
  assign wr_cmd = psel && penable && pwrite && clk_en && pstrb[0] &&
                  (paddr == MAS_COMMAND_OFS);
  assign cmd    = wr_cmd ? pwdata : MAS_ZERO32;

  // The control register holds origin, clear output and enables.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= MAS_CTL_RESET;
    end else if (wr_ctl) begin
      ctl_q <= pwdata[5:0];
    end
  end

  // Each request line holds until its own cause is cleared; set wins.
  mas_flag #(.WIDTH(3)) u_irq (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .set_in  (ev.irq_set),
    .clr_in  ({cmd[MAS_CMD_IRQ2_CLR], cmd[MAS_CMD_IRQ1_CLR], cmd[MAS_CMD_IRQ0_CLR]}),
    .flag_q  (irq_q)
  );

  // Fourth line latches a discard cause and interlocks the queue.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq3_q <= 1'b0;
    end else if (clk_en) begin
      if (ctl_q[MAS_CTL_RESV_EN] && (ev.reserve_cause || ev.error_lvl || ev.fstop_lvl)) begin
        irq3_q <= 1'b1;
      end else if (cmd[MAS_CMD_IRQ_CLR] || !ctl_q[MAS_CTL_RESV_EN]) begin
        irq3_q <= 1'b0;
      end
    end
  end

  // The cycle compare output is edge-latched until the cause clear command.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_q <= 1'b0;
    end else if (clk_en) begin
      if (ev.cycle_match) begin
        cyc_q <= 1'b1;
      end else if (cmd[MAS_CMD_IRQ_CLR]) begin
        cyc_q <= 1'b0;
      end
    end
  end

  // Settle wait: the end of pulses while settled is awaited.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_q <= 1'b0;
    end else if (clk_en) begin
      if (!ctl_q[MAS_CTL_SETTLE_EN]) begin
        settle_q <= 1'b0;
      end else if (servo_s.settled || ev.settle_timeout || ev.immediate_stop) begin
        settle_q <= 1'b0;
      end else if (ev.pulse_done) begin
        settle_q <= 1'b1;
      end
    end
  end

  // Counter compare flags clear on their own programmed release.
  mas_flag #(.WIDTH(3)) u_pos (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .set_in  (ev.pos_match),
    .clr_in  (ev.pos_release),
    .flag_q  (pos_cmp_q)
  );

  mas_flag #(.WIDTH(3)) u_pls (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .set_in  (ev.pls_match),
    .clr_in  (ev.pls_release),
    .flag_q  (pls_cmp_q)
  );

  // Overflow flags clear only on their preset commands; set wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_ovf_q <= 1'b0;
      pls_ovf_q <= 1'b0;
    end else if (clk_en) begin
      pos_ovf_q <= ev.pos_ovf | (pos_ovf_q & ~cmd[MAS_CMD_POS_PRE]);
      pls_ovf_q <= ev.pls_ovf | (pls_ovf_q & ~cmd[MAS_CMD_PLS_PRE]);
    end
  end

  // Status words are pure views; reading them has no side effect.
  always_comb begin
    st_servo = MAS_ZERO16;
    st_servo[MAS_ORIGIN_BIT]  = ctl_q[MAS_CTL_ORIGIN];
    st_servo[MAS_CLEAR_BIT]   = ctl_q[MAS_CTL_CLEAR];
    st_servo[MAS_SETTLED_BIT] = servo_s.settled;
    st_servo[MAS_ALARM_BIT]   = servo_s.alarm;
    st_servo[MAS_SETTLE_BIT]  = settle_q;
    st_irq = MAS_ZERO16;
    st_irq[MAS_IRQ_LO_BIT +: 3] = irq_q;
    st_irq[MAS_IRQ3_BIT]  = irq3_q;
    st_irq[MAS_GENERAL_OUTPUT_ZERO_BIT]  = ctl_q[MAS_CTL_GENERAL_OUTPUT_ZERO];
    st_irq[MAS_OUTA_BIT]  = ev.outa_lvl;
    st_irq[MAS_OUTB_BIT]  = ev.outb_lvl;
    st_irq[MAS_CYC_BIT]   = cyc_q;
    st_irq[MAS_GIO0_BIT]  = ev.error_lvl;
    st_irq[MAS_GIO1_BIT]  = ev.fstop_lvl;
    st_irq[MAS_IN0_BIT]   = servo_s.in0;
    st_cnt = MAS_ZERO16;
    st_cnt[MAS_POS_CMP_BIT +: 3] = pos_cmp_q;
    st_cnt[MAS_POS_OVF_BIT]      = pos_ovf_q;
    st_cnt[MAS_PLS_CMP_BIT +: 3] = pls_cmp_q;
    st_cnt[MAS_PLS_OVF_BIT]      = pls_ovf_q;
  end

  always_comb begin
    rd_d = MAS_ZERO32;
    case (paddr)
      MAS_SERVO_ORIGIN_STATUS_OFS:    rd_d = {16'h0000, st_servo};
      MAS_IRQ_AND_GP_IO_STATUS_OFS:   rd_d = {16'h0000, st_irq};
      MAS_COUNTER_COMPARE_STATUS_OFS: rd_d = {16'h0000, st_cnt};
      MAS_CONTROL_OFS:                rd_d = {26'h0000000, ctl_q};
      default:                        rd_d = MAS_ZERO32;
    endcase
  end

  // Read data is captured in setup so it leaves a flip-flop in the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= MAS_ZERO32;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !is_mapped(paddr);
      prdata  <= (psel && !penable && !pwrite) ? rd_d : MAS_ZERO32;
    end
  end

  // Axis- and bus-facing outputs, all registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      servo_clear_output  <= 1'b0;
      general_output_zero <= 1'b0;
      settle_wait_flag    <= 1'b0;
      axis_busy           <= 1'b0;
      reserve_queue_flush <= 1'b0;
      irq_line_three      <= 1'b0;
      inta_request        <= 1'b0;
    end else if (clk_en) begin
      servo_clear_output  <= ctl_q[MAS_CTL_CLEAR];
      general_output_zero <= ctl_q[MAS_CTL_GENERAL_OUTPUT_ZERO];
      settle_wait_flag    <= settle_q;
      axis_busy           <= settle_q;
      reserve_queue_flush <= irq3_q;
      irq_line_three      <= irq3_q;
      inta_request        <= ctl_q[MAS_CTL_INTA_EN] && (|irq_q);
    end
  end

  AST_SETTLE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && settle_q && servo_s.settled |=> !settle_q)
    else $error("Settle wait not cleared by settled input.");

  AST_SETTLE_SET: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && ctl_q[MAS_CTL_SETTLE_EN] && ev.pulse_done && !servo_s.settled &&
    !ev.settle_timeout && !ev.immediate_stop |=> settle_q)
    else $error("Settle wait not set after pulse end.");

  AST_IRQ_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && irq_q[0] && !cmd[MAS_CMD_IRQ0_CLR] |=> irq_q[0])
    else $error("Irq line zero dropped without clear.");

  AST_IRQ3_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    irq3_q && !cmd[MAS_CMD_IRQ_CLR] && ctl_q[MAS_CTL_RESV_EN] |=> irq3_q ##1 reserve_queue_flush)
    else $error("Fourth irq latch lost or flush missing.");

  AST_POS_OVF: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && ev.pos_ovf |=> pos_ovf_q)
    else $error("Position overflow not set.");

  AST_PLS_OVF: assert property (@(posedge pclk) disable iff (!presetn)
    pls_ovf_q && !cmd[MAS_CMD_PLS_PRE] |=> pls_ovf_q)
    else $error("Pulse overflow cleared without preset.");

  AST_RESV_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    st_irq[14:10] == 5'h00)
    else $error("Reserved status bits not zero.");

  AST_READY: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && psel && !penable ##1 clk_en |-> pready)
    else $error("Status read not answered.");

  AST_CLR_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> servo_clear_output == $past(ctl_q[MAS_CTL_CLEAR]))
    else $error("Clear output does not follow control.");
endmodule

// File: pkg/mas_pkg.sv
// Package for the motion axis status ports: register map, field positions, timing.
// Assumes a 32-bit APB slave on pclk; status words are 16 bits in the low lanes.
package mas_pkg;
  // Register byte offsets.
  localparam logic [11:0] MAS_SERVO_ORIGIN_STATUS_OFS    = 12'h000;
  localparam logic [11:0] MAS_IRQ_AND_GP_IO_STATUS_OFS   = 12'h004;
  localparam logic [11:0] MAS_COUNTER_COMPARE_STATUS_OFS = 12'h008;
  localparam logic [11:0] MAS_CONTROL_OFS                = 12'h00c;
  localparam logic [11:0] MAS_COMMAND_OFS                = 12'h010;
  // Servo and origin status field positions.
  localparam int MAS_ORIGIN_BIT    = 11;
  localparam int MAS_CLEAR_BIT     = 12;
  localparam int MAS_SETTLED_BIT   = 13;
  localparam int MAS_ALARM_BIT     = 14;
  localparam int MAS_SETTLE_BIT    = 15;
  // Interrupt and general I/O status field positions.
  localparam int MAS_IRQ_LO_BIT    = 0;
  localparam int MAS_IRQ3_BIT      = 3;
  localparam int MAS_GENERAL_OUTPUT_ZERO_BIT      = 4;
  localparam int MAS_OUTA_BIT      = 5;
  localparam int MAS_OUTB_BIT      = 6;
  localparam int MAS_CYC_BIT       = 7;
  localparam int MAS_GIO0_BIT      = 8;
  localparam int MAS_GIO1_BIT      = 9;
  localparam int MAS_IN0_BIT       = 15;
  // Counter compare status field positions.
  localparam int MAS_POS_CMP_BIT   = 0;
  localparam int MAS_POS_OVF_BIT   = 3;
  localparam int MAS_PLS_CMP_BIT   = 4;
  localparam int MAS_PLS_OVF_BIT   = 7;
  // Control register fields.
  localparam int MAS_CTL_ORIGIN    = 0;
  localparam int MAS_CTL_CLEAR     = 1;
  localparam int MAS_CTL_SETTLE_EN = 2;
  localparam int MAS_CTL_RESV_EN   = 3;
  localparam int MAS_CTL_GENERAL_OUTPUT_ZERO      = 4;
  localparam int MAS_CTL_INTA_EN   = 5;
  // Command register bits, write one to act.
  localparam int MAS_CMD_IRQ_CLR   = 0;
  localparam int MAS_CMD_POS_PRE   = 1;
  localparam int MAS_CMD_PLS_PRE   = 2;
  localparam int MAS_CMD_IRQ0_CLR  = 3;
  localparam int MAS_CMD_IRQ1_CLR  = 4;
  localparam int MAS_CMD_IRQ2_CLR  = 5;
  // Reset values.
  localparam logic [5:0]  MAS_CTL_RESET = 6'h00;
  localparam logic [15:0] MAS_ZERO16    = 16'h0000;
  localparam logic [31:0] MAS_ZERO32    = 32'h0000_0000;
  // Clock rate, kept for any later timing.
  localparam int MAS_CLK_HZ = 10_000_000;

  // Servo handshake inputs, all from pins.
  typedef struct packed {
    logic settled;
    logic alarm;
    logic in0;
  } mas_servo_in_t;

  // Event pulses and output levels from the axis engine, same clock domain.
  typedef struct packed {
    logic       pulse_done;
    logic       settle_timeout;
    logic       immediate_stop;
    logic [2:0] irq_set;
    logic       reserve_cause;
    logic       cycle_match;
    logic       error_lvl;
    logic       fstop_lvl;
    logic       outa_lvl;
    logic       outb_lvl;
    logic [2:0] pos_match;
    logic [2:0] pos_release;
    logic       pos_ovf;
    logic [2:0] pls_match;
    logic [2:0] pls_release;
    logic       pls_ovf;
  } mas_events_t;
endpackage

// File: hw/mas_sync.sv
// Two-stage synchroniser for a bundle of pin levels.
// Assumes the inputs come from outside the pclk domain.
`timescale 1ns/1ps
module mas_sync import mas_pkg::*; #(
  parameter int WIDTH = 3
) (
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  // Levels.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // Refused at elaboration, not at run time.
  if (WIDTH < 1) begin : g_width_check
    $error("mas_sync: WIDTH must be at least one.");
  end

  // The first stage is read only by the second.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// File: hw/mas_flag.sv
// Sticky flag bank: a set event wins over a clear in the same cycle.
// Assumes set and clear are single-cycle pulses on pclk.
`timescale 1ns/1ps
module mas_flag import mas_pkg::*; #(
  parameter int WIDTH = 3
) (
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  // Events.
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clr_in,
  output logic      [WIDTH-1:0] flag_q
);
  // Refused at elaboration, not at run time.
  if (WIDTH < 1) begin : g_width_check
    $error("mas_flag: WIDTH must be at least one.");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= '0;
    end else if (clk_en) begin
      flag_q <= set_in | (flag_q & ~clr_in);
    end
  end
endmodule

// File: testbench/mas_servo_model.sv
// Behavioural servo drive: settles after a set delay, alarms on request.
// Assumes the block's outputs are registered on pclk.
`timescale 1ns/1ps
module mas_servo_model (
  // Clock.
  input  wire logic       pclk,
  // From the block.
  input  wire logic       clear_in,
  input  wire logic       wait_in,
  // Scenario controls; a delay of zero drops the settled level and holds it low.
  input  wire logic [3:0] settle_dly,
  input  wire logic       alarm_req,
  input  wire logic       in0_req,
  // Pins to the block.
  output logic            settled,
  output logic            alarm,
  output logic            in0
);
  logic [3:0] cnt_q     = 4'h0;
  logic       wait_q    = 1'b0;
  logic       settled_q = 1'b0;
  logic       alarm_q   = 1'b0;
  // A new move or a delay of zero drops the in-position level; otherwise it stays up once reached.
  always @(posedge pclk) begin
    wait_q <= wait_in;
    if (wait_in && !wait_q) begin
      settled_q <= 1'b0;
      cnt_q     <= 4'h0;
    end else if (settle_dly == 4'h0) begin
      settled_q <= 1'b0;
    end else if (wait_in && cnt_q != settle_dly) begin
      cnt_q <= cnt_q + 4'h1;
    end else if (wait_in) begin
      settled_q <= 1'b1;
    end
    if (clear_in) begin
      alarm_q <= 1'b0;
    end else if (alarm_req) begin
      alarm_q <= 1'b1;
    end
  end
  assign settled = settled_q;
  assign alarm   = alarm_q;
  assign in0     = in0_req;
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the motion axis status ports.
// Assumes mas_pkg and the servo drive model are compiled first.
`timescale 1ns/1ps
module tb_top import mas_pkg::*;;
  logic          pclk = 1'b0;
  logic          presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, ctl;
  logic [3:0]    pstrb, settle_dly;
  mas_servo_in_t servo_in;
  mas_events_t   ev;
  logic          clr_o, general_output_zero_o, wait_o, busy_o, flush_o, irq3_o, inta_o;
  logic          alarm_req, in0_req, s_w, a_w, i_w;
  logic          en;
  int            error_cnt  = 0;
  int            num_checks = 0;
  localparam logic [11:0] SV = MAS_SERVO_ORIGIN_STATUS_OFS;
  localparam logic [11:0] IQ = MAS_IRQ_AND_GP_IO_STATUS_OFS;
  localparam logic [11:0] CN = MAS_COUNTER_COMPARE_STATUS_OFS;
  always #50 pclk = ~pclk;
  assign servo_in = '{settled: s_w, alarm: a_w, in0: i_w};
  mas_status uut (.pclk(pclk), .presetn(presetn), .clk_en(en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .servo_in(servo_in), .ev(ev),
    .servo_clear_output(clr_o), .general_output_zero(general_output_zero_o), .settle_wait_flag(wait_o),
    .axis_busy(busy_o), .reserve_queue_flush(flush_o), .irq_line_three(irq3_o),
    .inta_request(inta_o));
  mas_servo_model drv (.pclk(pclk), .clear_in(clr_o), .wait_in(wait_o),
    .settle_dly(settle_dly), .alarm_req(alarm_req), .in0_req(in0_req), .settled(s_w),
    .alarm(a_w), .in0(i_w));
  function automatic logic [31:0] b(input int i);
    return 32'h1 << i;
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Ends one edge after release, so back-to-back calls never collide.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n == 16) begin
      error_cnt++;
      $display("[FAIL] pready expected 1 seen timeout");
      give_verdict();
    end
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    logic        x;
    apb(1'b0, a, 32'h0, r, x);
    chk(nm, e, r);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        x;
    apb(1'b1, a, d, r, x);
  endtask
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    rd("servo", SV, 32'h0);
    rd("irq", IQ, 32'h0);
    rd("counter", CN, 32'h0);
    apb(1'b0, 12'h0f0, 32'h0, r, e);
    chk("unmapped", 32'h1, 32'(e));
    wr(SV, 32'hffff_ffff);
    rd("status write", SV, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_servo();
    alarm_req <= 1'b1;
    tick(1);
    alarm_req <= 1'b0;
    ctl = b(MAS_CTL_ORIGIN);
    wr(MAS_CONTROL_OFS, ctl);
    tick(3);
    rd("origin alarm", SV, b(MAS_ORIGIN_BIT) | b(MAS_ALARM_BIT));
    ctl = ctl | b(MAS_CTL_CLEAR);
    wr(MAS_CONTROL_OFS, ctl);
    tick(4);
    rd("clear", SV, b(MAS_ORIGIN_BIT) | b(MAS_CLEAR_BIT));
    chk("clear pin", 32'h1, 32'(clr_o));
    wr(MAS_CONTROL_OFS, 32'h0);
    rd("origin off", SV, 32'h0);
    $display("test servo done");
  endtask
  task automatic t_settle();
    ctl = b(MAS_CTL_SETTLE_EN);
    wr(MAS_CONTROL_OFS, ctl);
    settle_dly <= 4'h6;
    ev.pulse_done <= 1'b1;
    tick(1);
    ev.pulse_done <= 1'b0;
    rd("settle wait", SV, b(MAS_SETTLE_BIT));
    chk("busy and wait pins", 32'h1, 32'({busy_o, wait_o} == 2'b11));
    tick(12);
    rd("settled", SV, b(MAS_SETTLED_BIT));
    chk("idle", 32'h0, 32'(busy_o));
    settle_dly <= 4'h0;
    // The drive must drop its settled level, through the synchroniser, before the next move ends.
    tick(4);
    for (int i = 0; i < 2; i++) begin
      ev.pulse_done <= 1'b1;
      tick(1);
      ev.pulse_done <= 1'b0;
      tick(4);
      rd("slow wait", SV, b(MAS_SETTLE_BIT));
      if (i == 0) ev.settle_timeout <= 1'b1;
      else ev.immediate_stop <= 1'b1;
      tick(1);
      ev.settle_timeout <= 1'b0;
      ev.immediate_stop <= 1'b0;
      rd("forced end", SV, 32'h0);
    end
    $display("test settle done");
  endtask
  task automatic t_irq();
    wr(MAS_CONTROL_OFS, b(MAS_CTL_INTA_EN));
    ev.irq_set <= 3'h7;
    tick(1);
    ev.irq_set <= 3'h0;
    rd("irq set", IQ, 32'h7);
    rd("irq reread", IQ, 32'h7);
    chk("inta", 32'h1, 32'(inta_o));
    for (int i = 0; i < 3; i++) begin
      wr(MAS_COMMAND_OFS, b(MAS_CMD_IRQ0_CLR + i));
      rd("irq clear", IQ, 32'h7 & (32'h6 << i));
    end
    chk("inta off", 32'h0, 32'(inta_o));
    $display("test irq done");
  endtask
  task automatic t_gpio();
    ctl = b(MAS_CTL_GENERAL_OUTPUT_ZERO) | b(MAS_CTL_RESV_EN);
    wr(MAS_CONTROL_OFS, ctl);
    ev.outa_lvl  <= 1'b1;
    ev.outb_lvl  <= 1'b1;
    ev.error_lvl <= 1'b1;
    ev.fstop_lvl <= 1'b1;
    in0_req      <= 1'b1;
    ev.cycle_match <= 1'b1;
    tick(1);
    ev.cycle_match <= 1'b0;
    tick(3);
    rd("gpio on", IQ, 32'h0000_83f8);
    chk("flush", 32'h1, 32'({flush_o, irq3_o} == 2'b11));
    ev.outa_lvl  <= 1'b0;
    ev.outb_lvl  <= 1'b0;
    ev.error_lvl <= 1'b0;
    ev.fstop_lvl <= 1'b0;
    in0_req      <= 1'b0;
    tick(3);
    rd("latched", IQ, b(MAS_IRQ3_BIT) | b(MAS_GENERAL_OUTPUT_ZERO_BIT) | b(MAS_CYC_BIT));
    wr(MAS_COMMAND_OFS, b(MAS_CMD_IRQ_CLR));
    rd("cause clr", IQ, b(MAS_GENERAL_OUTPUT_ZERO_BIT));
    chk("general_output_zero pin", 32'h1, 32'({general_output_zero_o, flush_o} == 2'b10));
    ev.reserve_cause <= 1'b1;
    tick(1);
    ev.reserve_cause <= 1'b0;
    rd("resv cause", IQ, b(MAS_IRQ3_BIT) | b(MAS_GENERAL_OUTPUT_ZERO_BIT));
    wr(MAS_CONTROL_OFS, 32'h0);
    rd("general_output_zero off", IQ, 32'h0);
    $display("test gpio done");
  endtask
  task automatic t_count();
    // An overflow pulse while the clock enable is low must leave the flags untouched.
    en         <= 1'b0;
    ev.pos_ovf <= 1'b1;
    tick(1);
    ev.pos_ovf <= 1'b0;
    en         <= 1'b1;
    rd("frozen", CN, 32'h0);
    for (int i = 0; i < 3; i++) begin
      ev.pos_match <= 3'(1 << i);
      ev.pls_match <= 3'(1 << i);
      tick(1);
      ev.pos_match <= 3'h0;
      ev.pls_match <= 3'h0;
      rd("cmp set", CN, 32'h11 << i);
      ev.pos_release <= 3'(1 << i);
      ev.pls_release <= 3'(1 << i);
      tick(1);
      ev.pos_release <= 3'h0;
      ev.pls_release <= 3'h0;
      rd("cmp clr", CN, 32'h0);
    end
    ev.pos_ovf <= 1'b1;
    ev.pls_ovf <= 1'b1;
    tick(1);
    ev.pos_ovf <= 1'b0;
    ev.pls_ovf <= 1'b0;
    wr(MAS_COMMAND_OFS, b(MAS_CMD_IRQ_CLR));
    rd("ovf held", CN, 32'h88);
    wr(MAS_COMMAND_OFS, b(MAS_CMD_POS_PRE));
    rd("pos preset", CN, 32'h80);
    wr(MAS_COMMAND_OFS, b(MAS_CMD_PLS_PRE));
    rd("pls preset", CN, 32'h0);
    $display("test counter done");
  endtask
  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h0;
    pwdata     = 32'h0;
    pstrb      = 4'hf;
    ev         = '0;
    alarm_req  = 1'b0;
    in0_req    = 1'b0;
    settle_dly = 4'h0;
    ctl        = 32'h0;
    en         = 1'b1;
    tick(6);
    presetn <= 1'b1;
    tick(1);
    t_reset();
    t_servo();
    t_settle();
    t_irq();
    t_gpio();
    t_count();
    give_verdict();
  end
endmodule
